//--- pkg/snpe_pkg.sv
package snpe_pkg;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned CMD_BITS     = 8;
  localparam int unsigned PAYLOAD_BITS = 24;
  localparam int unsigned DATA_W       = 14;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned PC_W         = 16;
  localparam int unsigned LATCH_COUNT  = 64;
  localparam int unsigned ROW_SEL_W    = 6;
  localparam int unsigned LATCH_SEL_W  = 5;
  localparam int unsigned TIMER_W      = 21;
  localparam int unsigned PAD_BITS     = PAYLOAD_BITS - DATA_W - 2;

  localparam logic [7:0] CMD_LOAD_ADDR = 8'h80;
  localparam logic [7:0] CMD_BULK      = 8'h18;
  localparam logic [7:0] CMD_ROW_ERASE = 8'hF0;
  localparam logic [7:0] CMD_LOAD      = 8'h00;
  localparam logic [7:0] CMD_LOAD_INC  = 8'h02;
  localparam logic [7:0] CMD_READ_INC  = 8'hFE;
  localparam logic [7:0] CMD_READ      = 8'hFC;
  localparam logic [7:0] CMD_INC       = 8'hF8;
  localparam logic [7:0] CMD_INT_WRITE = 8'hE0;
  localparam logic [7:0] CMD_EXT_WRITE = 8'hC0;
  localparam logic [7:0] CMD_END_WRITE = 8'h82;
  localparam int unsigned INC_BIT      = 1;

  localparam logic [15:0] PROG_LAST    = 16'h7FFF;
  localparam logic [15:0] CFGSP_FIRST  = 16'h8000;
  localparam logic [15:0] UID_LAST     = 16'h8004;
  localparam logic [15:0] CFG_FIRST    = 16'h8007;
  localparam logic [15:0] CFG_LAST     = 16'h800B;
  localparam logic [15:0] BULK_ALL_END = 16'h80FD;
  localparam logic [15:0] CFGSP_LAST   = 16'h80FF;
  localparam logic [15:0] BULK_HI_ALL  = 16'hE800;
  localparam logic [15:0] EE_FIRST     = 16'hF000;
  localparam logic [15:0] EE_LAST      = 16'hF0FF;

  localparam int unsigned INT_WRITE_US     = 2800;
  localparam int unsigned INT_WRITE_CFG_US = 5600;
  localparam int unsigned BULK_ERASE_US    = 8400;
  localparam int unsigned ROW_ERASE_US     = 2800;
  localparam int unsigned INT_WRITE_CYC     = INT_WRITE_US * CLK_MHZ;
  localparam int unsigned INT_WRITE_CFG_CYC = INT_WRITE_CFG_US * CLK_MHZ;
  localparam int unsigned BULK_ERASE_CYC    = BULK_ERASE_US * CLK_MHZ;
  localparam int unsigned ROW_ERASE_CYC     = ROW_ERASE_US * CLK_MHZ;

  localparam int unsigned APB_AW     = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_PC      = 8'h08;
  localparam int unsigned CTRL_MODE  = 0;
  localparam int unsigned CTRL_CPB   = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h2;

  typedef enum logic [2:0] {
    SNPE_OP_NONE = 3'h0, SNPE_OP_WRITE = 3'h1, SNPE_OP_EXT_START = 3'h2,
    SNPE_OP_EXT_END = 3'h3, SNPE_OP_ROW_ERASE = 3'h4, SNPE_OP_BULK_ERASE = 3'h5
  } snpe_op_t;

  typedef enum logic [1:0] {
    SNPE_UNIT_ROW = 2'h0, SNPE_UNIT_WORD = 2'h1, SNPE_UNIT_BYTE = 2'h2
  } snpe_unit_t;

  typedef struct packed {
    logic           valid;
    snpe_op_t       op;
    snpe_unit_t     unit;
    logic [2:0]     regions;   // {user ids, config words, user flash}
    logic [15:0]    addr;
  } snpe_nvm_req_t;

  typedef enum logic {SNPE_LK_CMD = 1'b0, SNPE_LK_PAYLOAD = 1'b1} snpe_link_t;
  typedef enum logic [1:0] {
    SNPE_ST_IDLE = 2'b00, SNPE_ST_INT = 2'b01, SNPE_ST_ERASE = 2'b11, SNPE_ST_EXT = 2'b10
  } snpe_state_t;
endpackage

//--- src/snpe_engine.sv
// Chosen here: the register offsets and the APB interface to the registers.
module snpe_engine #(
  parameter int unsigned INT_WRITE_CYCLES     = snpe_pkg::INT_WRITE_CYC,
  parameter int unsigned INT_WRITE_CFG_CYCLES = snpe_pkg::INT_WRITE_CFG_CYC,
  parameter int unsigned BULK_ERASE_CYCLES    = snpe_pkg::BULK_ERASE_CYC,
  parameter int unsigned ROW_ERASE_CYCLES     = snpe_pkg::ROW_ERASE_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [snpe_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic                            pready_o,
  output logic [31:0]                     prdata_o,
  output logic                            pslverr_o,
  input  wire logic                       serial_clock_pin_i,
  input  wire logic                       serial_data_pin_i,
  output logic                            serial_data_pin_o,
  output logic                            serial_data_pin_oe_o,
  input  wire logic [snpe_pkg::DATA_W-1:0] nvm_rdata_i,
  output logic [snpe_pkg::PC_W-1:0]       nvm_raddr_o,
  output snpe_pkg::snpe_nvm_req_t         nvm_req_o,
  output logic [snpe_pkg::LATCH_COUNT*snpe_pkg::DATA_W-1:0] nvm_row_o
);
  localparam int unsigned DW = snpe_pkg::DATA_W;
  localparam int unsigned TW = snpe_pkg::TIMER_W;
  localparam int unsigned PB = snpe_pkg::PAYLOAD_BITS;

  logic                  sclk_meta_reg;
  logic                  sclk_sync_reg;
  logic                  sclk_prev_reg;
  logic                  sdat_meta_reg;
  logic                  sdat_sync_reg;
  logic                  clk_fall;
  logic                  clk_rise;
  logic [1:0]            ctrl_reg;
  logic                  mode_prev_reg;
  logic                  mode_en;
  logic                  mode_rise;
  logic                  unprot;
  snpe_pkg::snpe_link_t  link_reg;
  logic [4:0]            bit_cnt_reg;
  logic [7:0]            cmd_shift_reg;
  logic [7:0]            cmd_reg;
  logic [PB-1:0]         pay_shift_reg;
  logic [PB-1:0]         out_shift_reg;
  logic                  cmd_end_reg;
  logic                  pay_end_reg;
  logic [7:0]            cmd_full;
  logic                  last_bit;
  logic                  is_read;
  logic [snpe_pkg::PC_W-1:0] pc_reg;
  logic [DW-1:0]         latch_mem [snpe_pkg::LATCH_COUNT];
  logic                  latch_clr;
  logic                  unprot_set;
  snpe_pkg::snpe_state_t state_reg;
  logic [TW-1:0]         timer_reg;
  logic                  bulk_flash_reg;
  logic                  in_prog;
  logic                  in_uid;
  logic                  in_cfg;
  logic                  in_ee;
  logic                  wr_blocked;
  logic [2:0]            bulk_regions;
  snpe_pkg::snpe_unit_t  unit;
  logic [DW-1:0]         rd_word;
  logic                  apb_setup;

  function automatic logic has_payload(input logic [7:0] c);
    has_payload = (c == snpe_pkg::CMD_LOAD_ADDR) || (c == snpe_pkg::CMD_LOAD) ||
                  (c == snpe_pkg::CMD_LOAD_INC) || (c == snpe_pkg::CMD_READ) ||
                  (c == snpe_pkg::CMD_READ_INC);
  endfunction

  // Two-stage synchronisers; edges are found only after the second stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      sdat_meta_reg <= 1'b0;
      sdat_sync_reg <= 1'b0;
    end
    else
    begin
      sclk_meta_reg <= serial_clock_pin_i;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      sdat_meta_reg <= serial_data_pin_i;
      sdat_sync_reg <= sdat_meta_reg;
    end
  end

  assign clk_fall  = sclk_prev_reg & ~sclk_sync_reg;
  assign clk_rise  = ~sclk_prev_reg & sclk_sync_reg;
  assign mode_en   = ctrl_reg[snpe_pkg::CTRL_MODE];
  assign unprot    = ctrl_reg[snpe_pkg::CTRL_CPB];
  assign mode_rise = mode_en & ~mode_prev_reg;
  assign cmd_full  = {cmd_shift_reg[6:0], sdat_sync_reg};
  assign last_bit  = (link_reg == snpe_pkg::SNPE_LK_CMD) ? (bit_cnt_reg == 5'(snpe_pkg::CMD_BITS - 1))
                                                        : (bit_cnt_reg == 5'(PB - 1));
  assign is_read   = (cmd_reg == snpe_pkg::CMD_READ) || (cmd_reg == snpe_pkg::CMD_READ_INC);

  // Address class decode
  assign in_prog = (pc_reg <= snpe_pkg::PROG_LAST);
  assign in_uid  = (pc_reg >= snpe_pkg::CFGSP_FIRST) && (pc_reg <= snpe_pkg::UID_LAST);
  assign in_cfg  = (pc_reg >= snpe_pkg::CFG_FIRST) && (pc_reg <= snpe_pkg::CFG_LAST);
  assign in_ee   = (pc_reg >= snpe_pkg::EE_FIRST) && (pc_reg <= snpe_pkg::EE_LAST);
  assign wr_blocked = ~unprot & in_prog;

  always_comb
  begin
    if (in_ee)
      unit = snpe_pkg::SNPE_UNIT_BYTE;
    else if ((pc_reg >= snpe_pkg::CFGSP_FIRST) && (pc_reg <= snpe_pkg::CFGSP_LAST))
      unit = snpe_pkg::SNPE_UNIT_WORD;
    else
      unit = snpe_pkg::SNPE_UNIT_ROW;
  end

  // Region mask {user ids, config, user flash}
  always_comb
  begin
    if (in_prog)
      bulk_regions = 3'h1;
    else if (pc_reg <= snpe_pkg::BULK_ALL_END)
      bulk_regions = 3'h7;
    else if (pc_reg <= snpe_pkg::CFGSP_LAST)
      bulk_regions = 3'h1;
    else if (pc_reg < snpe_pkg::BULK_HI_ALL)
      bulk_regions = 3'h0;
    else
      bulk_regions = 3'h7;
  end

  // Only program memory is hidden; IDs, info areas and config stay visible
  always_comb
  begin
    if (~unprot && in_prog)
      rd_word = '0;
    else if (in_ee)
      rd_word = {{(DW - snpe_pkg::BYTE_W){1'b0}}, nvm_rdata_i[snpe_pkg::BYTE_W-1:0]};
    else
      rd_word = nvm_rdata_i;
  end

  assign nvm_raddr_o = pc_reg;

  // Link framing: 8 command bits, then 24 payload bits when the command has data
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !mode_en)
    begin
      link_reg      <= snpe_pkg::SNPE_LK_CMD;
      bit_cnt_reg   <= '0;
      cmd_shift_reg <= '0;
      cmd_reg       <= '0;
      pay_shift_reg <= '0;
      cmd_end_reg   <= 1'b0;
      pay_end_reg   <= 1'b0;
    end
    else
    begin
      cmd_end_reg <= 1'b0;
      pay_end_reg <= 1'b0;
      if (clk_fall)
      begin
        bit_cnt_reg <= last_bit ? 5'h00 : bit_cnt_reg + 5'h01;
        unique case (link_reg)
          snpe_pkg::SNPE_LK_CMD:
          begin
            cmd_shift_reg <= cmd_full;
            if (last_bit)
            begin
              cmd_reg <= cmd_full;
              if (has_payload(cmd_full))
                link_reg <= snpe_pkg::SNPE_LK_PAYLOAD;
              else
                cmd_end_reg <= 1'b1;
            end
          end
          snpe_pkg::SNPE_LK_PAYLOAD:
          begin
            pay_shift_reg <= {pay_shift_reg[PB-2:0], sdat_sync_reg};
            if (last_bit)
            begin
              link_reg    <= snpe_pkg::SNPE_LK_CMD;
              pay_end_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Read payload: load at command end, drive from first payload fall to 24th fall
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !mode_en)
    begin
      out_shift_reg        <= '0;
      serial_data_pin_o    <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
    end
    else if (link_reg == snpe_pkg::SNPE_LK_PAYLOAD && is_read)
    begin
      if (clk_fall && bit_cnt_reg == 5'h00)
      begin
        serial_data_pin_oe_o <= 1'b1;
        serial_data_pin_o    <= out_shift_reg[PB-1];
      end
      else if (clk_fall && last_bit)
        serial_data_pin_oe_o <= 1'b0;
      else if (clk_rise && serial_data_pin_oe_o)
      begin
        out_shift_reg     <= {out_shift_reg[PB-2:0], 1'b0};
        serial_data_pin_o <= out_shift_reg[PB-2];
      end
    end
    else if (clk_fall && link_reg == snpe_pkg::SNPE_LK_CMD && last_bit)
      out_shift_reg <= {1'b0, {snpe_pkg::PAD_BITS{1'b0}}, rd_word, 1'b0};
  end

  // Address counter
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || mode_rise)
      pc_reg <= '0;
    else if (pay_end_reg)
    begin
      if (cmd_reg == snpe_pkg::CMD_LOAD_ADDR)
        pc_reg <= pay_shift_reg[snpe_pkg::PC_W:1];
      else if (cmd_reg[snpe_pkg::INC_BIT])
        pc_reg <= pc_reg + 16'h0001;
    end
    else if (cmd_end_reg && cmd_reg == snpe_pkg::CMD_INC)
      pc_reg <= pc_reg + 16'h0001;
  end

  // Write latches; only the low five address bits pick the latch
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || latch_clr)
    begin
      for (int i = 0; i < int'(snpe_pkg::LATCH_COUNT); i++)
        latch_mem[i] <= '1;
    end
    else if (pay_end_reg && (cmd_reg == snpe_pkg::CMD_LOAD || cmd_reg == snpe_pkg::CMD_LOAD_INC))
    begin
      // Later loads to the same index simply replace earlier data
      if (in_ee)
        latch_mem[snpe_pkg::ROW_SEL_W'(pc_reg[snpe_pkg::LATCH_SEL_W-1:0])] <=
          {{(DW - snpe_pkg::BYTE_W){1'b0}}, pay_shift_reg[snpe_pkg::BYTE_W:1]};
      else
        latch_mem[snpe_pkg::ROW_SEL_W'(pc_reg[snpe_pkg::LATCH_SEL_W-1:0])] <=
          pay_shift_reg[DW:1];
    end
  end

  always_comb
  begin
    for (int i = 0; i < int'(snpe_pkg::LATCH_COUNT); i++)
      nvm_row_o[i*DW +: DW] = latch_mem[i];
  end

  // Operation sequencer; row address is the counter with its low bits masked
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !mode_en)
    begin
      state_reg      <= snpe_pkg::SNPE_ST_IDLE;
      timer_reg      <= '0;
      bulk_flash_reg <= 1'b0;
      latch_clr      <= 1'b0;
      unprot_set     <= 1'b0;
      nvm_req_o      <= '0;
    end
    else
    begin
      latch_clr       <= 1'b0;
      unprot_set      <= 1'b0;
      nvm_req_o.valid <= 1'b0;
      nvm_req_o.unit  <= unit;
      if (unit == snpe_pkg::SNPE_UNIT_ROW)
        nvm_req_o.addr <= {pc_reg[snpe_pkg::PC_W-1:snpe_pkg::ROW_SEL_W],
                           {snpe_pkg::ROW_SEL_W{1'b0}}};
      else
        nvm_req_o.addr <= pc_reg;
      unique case (state_reg)
        snpe_pkg::SNPE_ST_IDLE:
        begin
          if (cmd_end_reg)
          begin
            if (cmd_reg == snpe_pkg::CMD_INT_WRITE && !wr_blocked)
            begin
              nvm_req_o.valid   <= 1'b1;
              nvm_req_o.op      <= snpe_pkg::SNPE_OP_WRITE;
              nvm_req_o.regions <= 3'h0;
              timer_reg <= in_cfg ? TW'(INT_WRITE_CFG_CYCLES) : TW'(INT_WRITE_CYCLES);
              state_reg <= snpe_pkg::SNPE_ST_INT;
            end
            else if (cmd_reg == snpe_pkg::CMD_EXT_WRITE && !wr_blocked && !in_cfg)
            begin
              nvm_req_o.valid   <= 1'b1;
              nvm_req_o.op      <= snpe_pkg::SNPE_OP_EXT_START;
              nvm_req_o.regions <= 3'h0;
              state_reg <= snpe_pkg::SNPE_ST_EXT;
            end
            else if (cmd_reg == snpe_pkg::CMD_BULK && bulk_regions != 3'h0)
            begin
              nvm_req_o.valid   <= 1'b1;
              nvm_req_o.op      <= snpe_pkg::SNPE_OP_BULK_ERASE;
              nvm_req_o.regions <= bulk_regions;
              bulk_flash_reg    <= bulk_regions[0];
              timer_reg <= TW'(BULK_ERASE_CYCLES);
              state_reg <= snpe_pkg::SNPE_ST_ERASE;
            end
            else if (cmd_reg == snpe_pkg::CMD_ROW_ERASE && (in_uid || unprot))
            begin
              nvm_req_o.valid   <= 1'b1;
              nvm_req_o.op      <= snpe_pkg::SNPE_OP_ROW_ERASE;
              nvm_req_o.regions <= in_uid ? 3'h4 : 3'h1;
              bulk_flash_reg    <= 1'b0;
              timer_reg <= TW'(ROW_ERASE_CYCLES);
              state_reg <= snpe_pkg::SNPE_ST_ERASE;
            end
          end
        end
        snpe_pkg::SNPE_ST_EXT:
        begin
          // Bulk erase and other programming commands are dropped here
          if (cmd_end_reg && cmd_reg == snpe_pkg::CMD_END_WRITE)
          begin
            nvm_req_o.valid <= 1'b1;
            nvm_req_o.op    <= snpe_pkg::SNPE_OP_EXT_END;
            state_reg <= snpe_pkg::SNPE_ST_IDLE;
          end
        end
        snpe_pkg::SNPE_ST_INT,
        snpe_pkg::SNPE_ST_ERASE:
        begin
          // End-write and bulk erase are no-ops while self-timed work runs
          if (timer_reg <= TW'(1))
          begin
            state_reg  <= snpe_pkg::SNPE_ST_IDLE;
            latch_clr  <= (state_reg == snpe_pkg::SNPE_ST_INT);
            unprot_set <= (state_reg == snpe_pkg::SNPE_ST_ERASE) && bulk_flash_reg;
          end
          else
            timer_reg <= timer_reg - TW'(1);
        end
      endcase
    end
  end

  // APB slave, zero wait states; read data captured in the setup cycle
  assign pready_o  = 1'b1;
  assign apb_setup = psel_i & ~penable_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg      <= snpe_pkg::CTRL_RESET;
      mode_prev_reg <= 1'b0;
    end
    else
    begin
      mode_prev_reg <= mode_en;
      if (psel_i && penable_i && pwrite_i && paddr_i == snpe_pkg::OFS_CTRL)
        ctrl_reg <= pwdata_i[1:0];
      // Unprotect by bulk erase wins over a same-cycle software write
      if (unprot_set)
        ctrl_reg[snpe_pkg::CTRL_CPB] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr_o <= 1'b0;
      unique case (paddr_i)
        snpe_pkg::OFS_CTRL:   prdata_o <= {30'h0, ctrl_reg};
        snpe_pkg::OFS_STATUS: prdata_o <= {16'h0, cmd_reg, 5'h0,
                                           state_reg == snpe_pkg::SNPE_ST_EXT,
                                           state_reg != snpe_pkg::SNPE_ST_IDLE, mode_en};
        snpe_pkg::OFS_PC:     prdata_o <= {16'h0, pc_reg};
        default:
        begin
          prdata_o  <= '0;
          pslverr_o <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- verification/serial_nvm_program_engine_test.sv
module serial_nvm_program_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r32;
  logic pready, pslverr, sclk, line, dout, oe, err;
  logic [13:0] rdat, d;
  logic [15:0] raddr;
  logic [895:0] row;
  snpe_pkg::snpe_nvm_req_t req, lreq;
  int miscompares = 0, tests_run = 0, nreq = 0, en = 0;
  initial forever #4 clk = ~clk;
  assign rdat = raddr[13:0] ^ 14'h2A5A;
  always @(posedge clk)
    if (req.valid === 1'b1)
    begin
      lreq <= req;
      nreq <= nreq + 1;
    end
  snpe_engine #(.INT_WRITE_CYCLES(600), .INT_WRITE_CFG_CYCLES(800), .BULK_ERASE_CYCLES(600),
    .ROW_ERASE_CYCLES(400)) u_dut (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .serial_clock_pin_i(sclk),
    .serial_data_pin_i(line), .serial_data_pin_o(dout), .serial_data_pin_oe_o(oe),
    .nvm_rdata_i(rdat), .nvm_raddr_o(raddr), .nvm_req_o(req), .nvm_row_o(row));
  snpe_host_model u_host (.sclk_o(sclk), .line_o(line), .dev_d_i(dout), .dev_oe_i(oe));
  function automatic logic [31:0] mem(input logic [15:0] a);
    return {18'h0, a[13:0] ^ 14'h2A5A};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r32 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pc_is(input logic [15:0] e);
    apb(1'b0, snpe_pkg::OFS_PC, 32'h0);
    chk(r32, {16'h0, e});
  endtask
  task automatic idle();
    for (int i = 0; i < 500; i++)
    begin
      apb(1'b0, snpe_pkg::OFS_STATUS, 32'h0);
      if (r32[1] === 1'b0)
        break;
    end
    chk(r32[1], 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [23:0] r;
    u_host.shift(8, {16'h0, c}, 1'b0, r);
  endtask
  task automatic pay(input logic [7:0] c, input logic [23:0] p);
    logic [23:0] r;
    cmd(c);
    u_host.shift(24, p, 1'b0, r);
  endtask
  task automatic ld_pc(input logic [15:0] a);
    pay(8'h80, {7'h0, a, 1'b0});
  endtask
  task automatic rd(input logic [7:0] c);
    logic [23:0] r;
    cmd(c);
    u_host.shift(24, 24'h0, 1'b1, r);
    d = r[14:1];
  endtask
  task automatic rq(input int inc, input snpe_pkg::snpe_op_t op);
    en += inc;
    chk(nreq, en);
    if (inc != 0)
      chk(lreq.op, op);
  endtask
  task automatic t_addr();
    apb(1'b1, snpe_pkg::OFS_CTRL, 32'h3);
    ld_pc(16'h1234);
    pc_is(16'h1234);
    apb(1'b1, snpe_pkg::OFS_CTRL, 32'h2);
    apb(1'b1, snpe_pkg::OFS_CTRL, 32'h3);
    pc_is(16'h0000);
    apb(1'b0, 8'h40, 32'h0);
    chk({r32[30:0], err}, 32'h1);
    ld_pc(16'h0005);
    rd(8'hFE);
    chk(d, mem(16'h0005));
    pc_is(16'h0006);
    rd(8'hFC);
    chk(d, mem(16'h0006));
    pc_is(16'h0006);
    cmd(8'hF8);
    pc_is(16'h0007);
    ld_pc(16'hFFFF);
    cmd(8'hF8);
    pc_is(16'h0000);
    $display("address test done");
  endtask
  task automatic t_latch();
    ld_pc(16'h0041);
    pay(8'h02, {9'h0, 14'h1234, 1'b0});
    chk(row[14 +: 14], 14'h1234);
    pc_is(16'h0042);
    ld_pc(16'h0061);
    pay(8'h00, {9'h0, 14'h0ABC, 1'b0});
    chk(row[14 +: 14], 14'h0ABC);
    pc_is(16'h0061);
    cmd(8'hE0);
    rq(1, snpe_pkg::SNPE_OP_WRITE);
    chk(lreq.addr, 16'h0040);
    idle();
    chk(row[14 +: 14], 14'h3FFF);
    ld_pc(16'hF010);
    rd(8'hFC);
    chk(d, mem(16'hF010) & 32'h000000FF);
    pay(8'h00, {15'h0, 8'hA5, 1'b0});
    cmd(8'hE0);
    rq(1, snpe_pkg::SNPE_OP_WRITE);
    chk(lreq.unit, snpe_pkg::SNPE_UNIT_BYTE);
    idle();
    $display("latch test done");
  endtask
  task automatic t_prot();
    apb(1'b1, snpe_pkg::OFS_CTRL, 32'h1);
    ld_pc(16'h0010);
    rd(8'hFC);
    chk(d, 32'h0);
    ld_pc(16'h8000);
    rd(8'hFC);
    chk(d, mem(16'h8000));
    ld_pc(16'h0010);
    cmd(8'hF0);
    rq(0, snpe_pkg::SNPE_OP_NONE);
    cmd(8'hE0);
    rq(0, snpe_pkg::SNPE_OP_NONE);
    ld_pc(16'h8002);
    cmd(8'hF0);
    rq(1, snpe_pkg::SNPE_OP_ROW_ERASE);
    idle();
    $display("protect test done");
  endtask
  task automatic t_bulk();
    logic [15:0] a [5] = '{16'h0000, 16'h8000, 16'h80FE, 16'h8100, 16'hE800};
    logic [2:0] g [5] = '{3'h1, 3'h7, 3'h1, 3'h0, 3'h7};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, snpe_pkg::OFS_CTRL, 32'h1);
      ld_pc(a[i]);
      cmd(8'h18);
      rq(int'(g[i] != 3'h0), snpe_pkg::SNPE_OP_BULK_ERASE);
      if (g[i] != 3'h0)
        chk(lreq.regions, g[i]);
      idle();
      apb(1'b0, snpe_pkg::OFS_CTRL, 32'h0);
      chk(r32[1], g[i][0]);
    end
    $display("bulk test done");
  endtask
  task automatic t_ext();
    ld_pc(16'h8007);
    cmd(8'hC0);
    cmd(8'h82);
    rq(0, snpe_pkg::SNPE_OP_NONE);
    ld_pc(16'h0000);
    pay(8'h00, {9'h0, 14'h0155, 1'b0});
    cmd(8'hC0);
    rq(1, snpe_pkg::SNPE_OP_EXT_START);
    cmd(8'h18);
    rq(0, snpe_pkg::SNPE_OP_NONE);
    cmd(8'h82);
    rq(1, snpe_pkg::SNPE_OP_EXT_END);
    idle();
    cmd(8'hE0);
    cmd(8'h18);
    cmd(8'h82);
    rq(1, snpe_pkg::SNPE_OP_WRITE);
    idle();
    $display("external write test done");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_addr();
    t_latch();
    t_prot();
    t_bulk();
    t_ext();
    final_report();
  end
  initial
  begin
    #700000;
    miscompares++;
    final_report();
  end
endmodule

//--- verification/snpe_engine_asserts.sv
module snpe_engine_asserts #(
  parameter int unsigned INT_WRITE_CFG_CYCLES = 800
) (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [7:0]              paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic                    serial_data_pin_o,
  input wire logic                    serial_data_pin_oe_o,
  input wire logic [15:0]             nvm_raddr_o,
  input wire snpe_pkg::snpe_nvm_req_t nvm_req_o,
  input wire logic [895:0]            nvm_row_o
);
  localparam int WMAX = INT_WRITE_CFG_CYCLES + 8;
  logic       cp_q;
  logic       mode_q;
  logic [9:0] oe_n;
  wire        wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == snpe_pkg::OFS_CTRL;
  wire        v = nvm_req_o.valid;
  wire [15:0] a = nvm_req_o.addr;
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  function automatic logic [2:0] bulk_exp(input logic [15:0] x);
    if ((x >= 16'h8000 && x <= 16'h80FD) || x >= 16'hE800)
      return 3'h7;
    return (x < 16'h8100) ? 3'h1 : 3'h0;
  endfunction
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      cp_q <= 1'b1;
    else if (v && nvm_req_o.op == snpe_pkg::SNPE_OP_BULK_ERASE && nvm_req_o.regions[0])
      cp_q <= 1'b1;
    else if (wr_ctrl)
      cp_q <= pwdata_i[1];
  end
  always_ff @(posedge clk_i)
    mode_q <= !rst_b_i ? 1'b0 : (wr_ctrl ? pwdata_i[0] : mode_q);
  // Span assumes the 160 ns link clock of the bench
  always_ff @(posedge clk_i)
    oe_n <= (!rst_b_i || !serial_data_pin_oe_o) ? 10'h000 : oe_n + 10'h001;
  property p_pc_clear;
    wr_ctrl && pwdata_i[0] && !mode_q |-> ##[1:2] nvm_raddr_o == 16'h0000;
  endproperty
  property p_read_span;
    $fell(serial_data_pin_oe_o) |-> oe_n >= 10'h1C7 && oe_n <= 10'h1D1;
  endproperty
  property p_cp_zero;
    serial_data_pin_oe_o && !cp_q && nvm_raddr_o <= 16'h7FFF |-> !serial_data_pin_o;
  endproperty
  property p_row_ones;
    v && nvm_req_o.op == snpe_pkg::SNPE_OP_WRITE && nvm_req_o.unit == snpe_pkg::SNPE_UNIT_ROW
      |-> ##[1:WMAX] (&nvm_row_o);
  endproperty
  property p_row_cp;
    v && nvm_req_o.op == snpe_pkg::SNPE_OP_ROW_ERASE && !cp_q |-> a >= 16'h8000 && a <= 16'h8004;
  endproperty
  property p_ext_cfg;
    v && nvm_req_o.op == snpe_pkg::SNPE_OP_EXT_START |-> !(a >= 16'h8007 && a <= 16'h800B);
  endproperty
  property p_bulk;
    v && nvm_req_o.op == snpe_pkg::SNPE_OP_BULK_ERASE |-> nvm_req_o.regions == bulk_exp(a);
  endproperty
  property p_row_align;
    v && nvm_req_o.unit == snpe_pkg::SNPE_UNIT_ROW |-> a[5:0] == 6'h00;
  endproperty
  property p_ee_byte;
    v && nvm_req_o.op == snpe_pkg::SNPE_OP_WRITE && a >= 16'hF000 && a <= 16'hF0FF
      |-> nvm_req_o.unit == snpe_pkg::SNPE_UNIT_BYTE;
  endproperty
  a_pc_clear: assert property (p_pc_clear)
    else $error("address kept on mode entry");
  a_read_span: assert property (p_read_span)
    else $error("read drive span wrong");
  a_cp_zero: assert property (p_cp_zero)
    else $error("protected word leaked");
  a_row_ones: assert property (p_row_ones)
    else $error("latches not set after write");
  a_row_cp: assert property (p_row_cp)
    else $error("row erase while protected");
  a_ext_cfg: assert property (p_ext_cfg)
    else $error("external write to config");
  a_bulk: assert property (p_bulk)
    else $error("bulk regions wrong");
  a_row_align: assert property (p_row_align)
    else $error("row address not aligned");
  a_ee_byte: assert property (p_ee_byte)
    else $error("eeprom write not byte");
  c_read: cover property ($fell(serial_data_pin_oe_o));
  c_bulk: cover property (v && nvm_req_o.op == snpe_pkg::SNPE_OP_BULK_ERASE);
  c_ext: cover property (v && nvm_req_o.op == snpe_pkg::SNPE_OP_EXT_END);
endmodule
bind snpe_engine snpe_engine_asserts #(.INT_WRITE_CFG_CYCLES(INT_WRITE_CFG_CYCLES)) u_chk (
  .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .serial_data_pin_o,
  .serial_data_pin_oe_o, .nvm_raddr_o, .nvm_req_o, .nvm_row_o);

//--- verification/snpe_host_model.sv
module snpe_host_model (
  output logic      sclk_o,
  output logic      line_o,
  input  wire logic dev_d_i,
  input  wire logic dev_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hd = 1'b0;
  logic drv = 1'b1;
  logic junk = 1'b0;
  initial sclk_o = 1'b0;
  always #8 junk = ~junk;
  // A released line toggles so a stale bit never passes for data
  assign line_o = dev_oe_i ? dev_d_i : (drv ? hd : junk);
  task automatic shift(input int n, input logic [23:0] val, input logic rd,
                       output logic [23:0] r);
    r = 24'h000000;
    // Start on the clock's falling grid so no link edge meets a sampling edge
    @(junk);
    drv = !rd;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_o = 1'b1;
      hd = val[i];
      #80 r[i] = line_o;
      sclk_o = 1'b0;
      #80;
    end
    drv = 1'b1;
    // Clock stands low between frames; gap covers the command turnaround
    #1000;
  endtask
endmodule
